// *** rtl/gpcb_params.svh ***
`ifndef GPCB_PARAMS_SVH
`define GPCB_PARAMS_SVH
`define GPCB_ADDR_W 8
`define GPCB_NUM_PINS 9
`define GPCB_NUM_B1 8
`define GPCB_IDX_DEV_DISABLE 6'h22
`define GPCB_IDX_BANK1_PIN0_CFG 6'h23
`define GPCB_IDX_BANK1_PIN1_CFG 6'h24
`define GPCB_IDX_BANK1_PIN2_CFG 6'h25
`define GPCB_IDX_BANK1_PIN3_CFG 6'h26
`define GPCB_IDX_BANK1_PIN4_CFG 6'h27
`define GPCB_IDX_BANK1_PIN5_CFG 6'h28
`define GPCB_IDX_BANK1_PIN6_CFG 6'h29
`define GPCB_IDX_BANK1_PIN7_CFG 6'h2a
`define GPCB_IDX_BANK2_PIN0_CFG 6'h2b
`define GPCB_BIT_DIR 0
`define GPCB_BIT_POL 1
`define GPCB_BIT_ALT 2
`define GPCB_BIT_FUNC_LO 2
`define GPCB_BIT_FUNC_HI 3
`define GPCB_BIT_OD 7
`define GPCB_BIT_LOCK 1
`define GPCB_B1_RST 8'h04
`define GPCB_B2_RST 8'h01
`define GPCB_DEV_DISABLE_RST 8'h00
`define GPCB_B1_WMASK 8'h87
`define GPCB_B2_WMASK 8'h8f
`define GPCB_DEV_DISABLE_WMASK 8'heb
`define GPCB_RESP_OKAY 2'h0
`define GPCB_RESP_SLVERR 2'h2
`endif

// *** rtl/gpcb_pkg.sv ***
package gpcb_pkg;
  typedef enum logic [1:0] {
    GPCB_FN_GPIO,
    GPCB_FN_KBC,
    GPCB_FN_FDS,
    GPCB_FN_RSVD
  } gpcb_func_e;
  typedef logic [7:0] gpcb_cfg_t;
  typedef logic [5:0] gpcb_idx_t;
endpackage : gpcb_pkg

// *** rtl/gpcb_pin_cell.sv ***
module gpcb_pin_cell
  import gpcb_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic pin_i,
  output logic pin_o,
  output logic pin_oe,
  input wire logic out_val,
  input wire logic out_en,
  input wire logic invert,
  input wire logic open_drain,
  output logic in_val
);
  logic sync1_reg;
  logic sync2_reg;
  logic drive_val;

  // Two-stage synchroniser for the pad input
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
    end else if (ce) begin
      sync1_reg <= pin_i;
      sync2_reg <= sync1_reg;
    end
  end

  assign drive_val = out_val ^ invert;
  assign pin_o = open_drain ? 1'b0 : drive_val;
  assign pin_oe = open_drain ? (out_en & ~drive_val) : out_en;
  assign in_val = sync2_reg ^ invert;
endmodule : gpcb_pin_cell

// *** rtl/gpcb_axil_slave.sv ***
`include "gpcb_params.svh"
module gpcb_axil_slave
  import gpcb_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic [7:0] s_axil_awaddr,
  input wire logic s_axil_awvalid,
  output logic s_axil_awready,
  input wire logic [31:0] s_axil_wdata,
  input wire logic [3:0] s_axil_wstrb,
  input wire logic s_axil_wvalid,
  output logic s_axil_wready,
  output logic [1:0] s_axil_bresp,
  output logic s_axil_bvalid,
  input wire logic s_axil_bready,
  input wire logic [7:0] s_axil_araddr,
  input wire logic s_axil_arvalid,
  output logic s_axil_arready,
  output logic [31:0] s_axil_rdata,
  output logic [1:0] s_axil_rresp,
  output logic s_axil_rvalid,
  input wire logic s_axil_rready,
  output logic wr_pulse,
  output gpcb_idx_t wr_idx,
  output logic [7:0] wr_data,
  output logic wr_strb0,
  input wire logic wr_err,
  output gpcb_idx_t rd_idx,
  input wire logic [7:0] rd_data,
  input wire logic rd_err
);
  logic aw_held_reg;
  logic w_held_reg;
  logic bvalid_reg;
  logic rvalid_reg;
  logic [3:0] wstrb_reg;

  assign s_axil_awready = ce & ~aw_held_reg;
  assign s_axil_wready = ce & ~w_held_reg;
  assign s_axil_arready = ce & ~rvalid_reg;
  assign s_axil_bvalid = ce & bvalid_reg;
  assign s_axil_rvalid = ce & rvalid_reg;
  assign wr_pulse = ce & aw_held_reg & w_held_reg & ~bvalid_reg;
  assign wr_strb0 = wstrb_reg[0];
  assign rd_idx = s_axil_araddr[7:2];

  // Write address and data are held independently until both are present
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      wr_idx <= '0;
    end else if (s_axil_awvalid && s_axil_awready) begin
      aw_held_reg <= 1'b1;
      wr_idx <= s_axil_awaddr[7:2];
    end else if (wr_pulse) begin
      aw_held_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_reg <= 1'b0;
      wr_data <= 8'h00;
      wstrb_reg <= 4'h0;
    end else if (s_axil_wvalid && s_axil_wready) begin
      w_held_reg <= 1'b1;
      wr_data <= s_axil_wdata[7:0];
      wstrb_reg <= s_axil_wstrb;
    end else if (wr_pulse) begin
      w_held_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_reg <= 1'b0;
      s_axil_bresp <= `GPCB_RESP_OKAY;
    end else if (wr_pulse) begin
      bvalid_reg <= 1'b1;
      s_axil_bresp <= wr_err ? `GPCB_RESP_SLVERR : `GPCB_RESP_OKAY;
    end else if (s_axil_bvalid && s_axil_bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      s_axil_rdata <= 32'h0000_0000;
      s_axil_rresp <= `GPCB_RESP_OKAY;
    end else if (s_axil_arvalid && s_axil_arready) begin
      rvalid_reg <= 1'b1;
      s_axil_rdata <= {24'h00_0000, rd_data};
      s_axil_rresp <= rd_err ? `GPCB_RESP_SLVERR : `GPCB_RESP_OKAY;
    end else if (s_axil_rvalid && s_axil_rready) begin
      rvalid_reg <= 1'b0;
    end
  end
endmodule : gpcb_axil_slave

// *** rtl/gpcb_top.sv ***
`include "gpcb_params.svh"
module gpcb_top
  import gpcb_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic standby_por_n,
  input wire logic [7:0] s_axil_awaddr,
  input wire logic [2:0] s_axil_awprot,
  input wire logic s_axil_awvalid,
  output logic s_axil_awready,
  input wire logic [31:0] s_axil_wdata,
  input wire logic [3:0] s_axil_wstrb,
  input wire logic s_axil_wvalid,
  output logic s_axil_wready,
  output logic [1:0] s_axil_bresp,
  output logic s_axil_bvalid,
  input wire logic s_axil_bready,
  input wire logic [7:0] s_axil_araddr,
  input wire logic [2:0] s_axil_arprot,
  input wire logic s_axil_arvalid,
  output logic s_axil_arready,
  output logic [31:0] s_axil_rdata,
  output logic [1:0] s_axil_rresp,
  output logic s_axil_rvalid,
  input wire logic s_axil_rready,
  input wire logic [8:0] pin_i,
  output logic [8:0] pin_o,
  output logic [8:0] pin_oe,
  input wire logic [8:0] gpio_out_data,
  output logic [8:0] gpio_in_data,
  input wire logic [7:0] exp_bus_data_out,
  input wire logic [7:0] exp_bus_data_oe,
  output logic [7:0] exp_bus_data_in,
  output logic [7:0] exp_bus_sel,
  input wire logic floppy_drive_select_1_n,
  input wire logic kbc_port1_bit7_out,
  output logic kbc_port1_bit7_in,
  output logic [1:0] bank2_pin0_func,
  output logic [7:0] device_disable,
  output logic reg_lock
);
  gpcb_cfg_t cfg_reg [0:8];
  logic [71:0] cfg_flat;
  logic [7:0] dev_disable_reg;
  logic wr_pulse;
  gpcb_idx_t wr_idx;
  logic [7:0] wr_data;
  logic wr_strb0;
  logic wr_err;
  logic wr_allow;
  gpcb_idx_t rd_idx;
  logic [7:0] rd_data;
  logic rd_err;
  logic [8:0] out_val;
  logic [8:0] out_en;
  logic [8:0] in_val;
  gpcb_func_e b2_func;
  logic b2_val;
  logic b2_en;

  function automatic logic slot_hit(input gpcb_idx_t idx, input int slot);
    return idx == gpcb_idx_t'(`GPCB_IDX_BANK1_PIN0_CFG + slot);
  endfunction : slot_hit

  function automatic logic is_mapped(input gpcb_idx_t idx);
    return (idx >= `GPCB_IDX_DEV_DISABLE) && (idx <= `GPCB_IDX_BANK2_PIN0_CFG);
  endfunction : is_mapped

  function automatic gpcb_cfg_t cfg_wmask(input int slot);
    return (slot == `GPCB_NUM_B1) ? `GPCB_B2_WMASK : `GPCB_B1_WMASK;
  endfunction : cfg_wmask

  function automatic gpcb_cfg_t cfg_reset(input int slot);
    return (slot == `GPCB_NUM_B1) ? `GPCB_B2_RST : `GPCB_B1_RST;
  endfunction : cfg_reset

  gpcb_axil_slave u_axil (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .s_axil_awaddr(s_axil_awaddr),
    .s_axil_awvalid(s_axil_awvalid),
    .s_axil_awready(s_axil_awready),
    .s_axil_wdata(s_axil_wdata),
    .s_axil_wstrb(s_axil_wstrb),
    .s_axil_wvalid(s_axil_wvalid),
    .s_axil_wready(s_axil_wready),
    .s_axil_bresp(s_axil_bresp),
    .s_axil_bvalid(s_axil_bvalid),
    .s_axil_bready(s_axil_bready),
    .s_axil_araddr(s_axil_araddr),
    .s_axil_arvalid(s_axil_arvalid),
    .s_axil_arready(s_axil_arready),
    .s_axil_rdata(s_axil_rdata),
    .s_axil_rresp(s_axil_rresp),
    .s_axil_rvalid(s_axil_rvalid),
    .s_axil_rready(s_axil_rready),
    .wr_pulse(wr_pulse),
    .wr_idx(wr_idx),
    .wr_data(wr_data),
    .wr_strb0(wr_strb0),
    .wr_err(wr_err),
    .rd_idx(rd_idx),
    .rd_data(rd_data),
    .rd_err(rd_err)
  );

  assign wr_err = ~is_mapped(wr_idx);
  assign rd_err = ~is_mapped(rd_idx);
  assign reg_lock = dev_disable_reg[`GPCB_BIT_LOCK];
  assign device_disable = dev_disable_reg;
  assign wr_allow = wr_pulse & wr_strb0 & ~reg_lock;

  // Lock register; the lock bit also clears on bus reset
  always_ff @(posedge aclk) begin
    if (!standby_por_n) begin
      dev_disable_reg <= `GPCB_DEV_DISABLE_RST;
    end else if (!aresetn) begin
      dev_disable_reg[`GPCB_BIT_LOCK] <= 1'b0;
    end else if (wr_allow && (wr_idx == `GPCB_IDX_DEV_DISABLE)) begin
      dev_disable_reg <= wr_data & `GPCB_DEV_DISABLE_WMASK;
    end
  end

  // Pin configuration registers
  for (genvar i = 0; i < `GPCB_NUM_PINS; i++) begin : g_cfg
    always_ff @(posedge aclk) begin
      if (!standby_por_n) begin
        cfg_reg[i] <= cfg_reset(i);
      end else if (wr_allow && slot_hit(wr_idx, i)) begin
        cfg_reg[i] <= wr_data & cfg_wmask(i);
      end
    end
    assign cfg_flat[i*8 +: 8] = cfg_reg[i];
  end

  always_comb begin
    rd_data = 8'h00;
    if (rd_idx == `GPCB_IDX_DEV_DISABLE) begin
      rd_data = dev_disable_reg;
    end else begin
      for (int k = 0; k < `GPCB_NUM_PINS; k++) begin
        if (slot_hit(rd_idx, k)) begin
          rd_data = cfg_reg[k];
        end
      end
    end
  end

  // Bank 1 function selection
  for (genvar i = 0; i < `GPCB_NUM_B1; i++) begin : g_bank1
    assign exp_bus_sel[i] = cfg_reg[i][`GPCB_BIT_ALT];
    assign out_val[i] = exp_bus_sel[i] ? exp_bus_data_out[i] : gpio_out_data[i];
    assign out_en[i] = ~cfg_reg[i][`GPCB_BIT_DIR] & (~exp_bus_sel[i] | exp_bus_data_oe[i]);
    assign exp_bus_data_in[i] = exp_bus_sel[i] & in_val[i];
  end

  // Bank 2 pin 0 function selection
  assign b2_func = gpcb_func_e'(cfg_reg[8][`GPCB_BIT_FUNC_HI:`GPCB_BIT_FUNC_LO]);
  assign bank2_pin0_func = b2_func;

  always_comb begin
    b2_val = 1'b0;
    b2_en = 1'b0;
    case (b2_func)
      GPCB_FN_GPIO: begin
        b2_val = gpio_out_data[8];
        b2_en = 1'b1;
      end
      GPCB_FN_KBC: begin
        b2_val = kbc_port1_bit7_out;
        b2_en = 1'b1;
      end
      GPCB_FN_FDS: begin
        b2_val = floppy_drive_select_1_n;
        b2_en = 1'b1;
      end
      default: begin
        b2_val = 1'b0;
        b2_en = 1'b0;
      end
    endcase
  end

  assign out_val[8] = b2_val;
  assign out_en[8] = ~cfg_reg[8][`GPCB_BIT_DIR] & b2_en;
  assign kbc_port1_bit7_in = (b2_func == GPCB_FN_KBC) ? in_val[8] : 1'b1;
  assign gpio_in_data = in_val;

  for (genvar i = 0; i < `GPCB_NUM_PINS; i++) begin : g_pin
    gpcb_pin_cell u_cell (
      .aclk(aclk),
      .aresetn(aresetn),
      .ce(ce),
      .pin_i(pin_i[i]),
      .pin_o(pin_o[i]),
      .pin_oe(pin_oe[i]),
      .out_val(out_val[i]),
      .out_en(out_en[i]),
      .invert(cfg_reg[i][`GPCB_BIT_POL]),
      .open_drain(cfg_reg[i][`GPCB_BIT_OD]),
      .in_val(in_val[i])
    );
  end

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn || !standby_por_n);

  property p_dir_input;
    cfg_reg[3][`GPCB_BIT_DIR] |-> !pin_oe[3];
  endproperty
  a_dir_input: assert property (p_dir_input) else $error("input pin is driven");

  property p_polarity;
    !cfg_reg[0][`GPCB_BIT_DIR] && !cfg_reg[0][`GPCB_BIT_ALT] && !cfg_reg[0][`GPCB_BIT_OD]
      |-> pin_oe[0] && (pin_o[0] == (gpio_out_data[0] ^ cfg_reg[0][`GPCB_BIT_POL]));
  endproperty
  a_polarity: assert property (p_polarity) else $error("pin value ignores polarity");

  property p_open_drain;
    cfg_reg[8][`GPCB_BIT_OD] |-> !pin_o[8] && !(pin_oe[8] && (out_val[8] ^ cfg_reg[8][`GPCB_BIT_POL]));
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("open drain pin drives high");

  property p_exp_bus;
    cfg_reg[5][`GPCB_BIT_ALT] && !cfg_reg[5][`GPCB_BIT_DIR] && !cfg_reg[5][`GPCB_BIT_OD]
      && !cfg_reg[5][`GPCB_BIT_POL] |-> pin_o[5] == exp_bus_data_out[5] && pin_oe[5] == exp_bus_data_oe[5];
  endproperty
  a_exp_bus: assert property (p_exp_bus) else $error("expansion bus data not routed");

  property p_b1_reset;
    disable iff (1'b0) !standby_por_n |=> cfg_reg[0] == `GPCB_B1_RST && cfg_reg[7] == `GPCB_B1_RST;
  endproperty
  a_b1_reset: assert property (p_b1_reset) else $error("bank 1 default wrong");

  property p_func_gpio;
    b2_func == GPCB_FN_GPIO && !cfg_reg[8][`GPCB_BIT_DIR] |-> pin_oe[8] || cfg_reg[8][`GPCB_BIT_OD];
  endproperty
  a_func_gpio: assert property (p_func_gpio) else $error("plain I/O output not driven");

  property p_func_rsvd;
    b2_func == GPCB_FN_RSVD |-> !pin_oe[8];
  endproperty
  a_func_rsvd: assert property (p_func_rsvd) else $error("reserved function drives pin");

  property p_floppy;
    b2_func == GPCB_FN_FDS && !cfg_reg[8][`GPCB_BIT_DIR] && !cfg_reg[8][`GPCB_BIT_OD]
      |-> pin_oe[8] && pin_o[8] == (floppy_drive_select_1_n ^ cfg_reg[8][`GPCB_BIT_POL]);
  endproperty
  a_floppy: assert property (p_floppy) else $error("floppy select not on pin");

  property p_kbc_in;
    b2_func == GPCB_FN_KBC && cfg_reg[8][`GPCB_BIT_DIR] && !cfg_reg[8][`GPCB_BIT_POL] && $stable(pin_i[8]) && ce
      ##1 $stable(pin_i[8]) && $stable(cfg_reg[8]) && ce
      ##1 $stable(pin_i[8]) && $stable(cfg_reg[8]) |-> kbc_port1_bit7_in == pin_i[8];
  endproperty
  a_kbc_in: assert property (p_kbc_in) else $error("keyboard port bit does not follow pin");

  property p_b2_reset;
    disable iff (1'b0) !standby_por_n |=> cfg_reg[8] == `GPCB_B2_RST;
  endproperty
  a_b2_reset: assert property (p_b2_reset) else $error("bank 2 default wrong");

  property p_lock_hold;
    reg_lock |=> $stable(cfg_flat) && $stable(dev_disable_reg);
  endproperty
  a_lock_hold: assert property (p_lock_hold) else $error("locked register changed");

  property p_lock_clear;
    disable iff (!standby_por_n) !aresetn |=> !reg_lock;
  endproperty
  a_lock_clear: assert property (p_lock_clear) else $error("lock survives bus reset");

  property p_reserved;
    (cfg_reg[2] & ~`GPCB_B1_WMASK) == 8'h00 && (cfg_reg[8] & ~`GPCB_B2_WMASK) == 8'h00;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bit set");

  property p_write_resp;
    wr_pulse |=> s_axil_bvalid || !ce;
  endproperty
  a_write_resp: assert property (p_write_resp) else $error("write response missing");

  c_lock: cover property (wr_allow && wr_idx == `GPCB_IDX_DEV_DISABLE && wr_data[`GPCB_BIT_LOCK]);
  c_floppy: cover property (b2_func == GPCB_FN_FDS && pin_oe[8]);
  c_exp_bus: cover property (exp_bus_sel == 8'hff ##1 cfg_reg[0][`GPCB_BIT_ALT] == 1'b0);
  c_unmapped: cover property (s_axil_rvalid && s_axil_rresp == `GPCB_RESP_SLVERR);
endmodule : gpcb_top

// *** bench/gpcb_board_model.sv ***
module gpcb_board_model (
  input wire logic [8:0] pin_o,
  input wire logic [8:0] pin_oe,
  input wire logic [8:0] ext_drv,
  output logic [8:0] pin_i
);
  timeunit 1ns;
  timeprecision 1ns;
  // Driven pads show the device value, released pads the external device level
  assign pin_i = (pin_oe & pin_o) | (~pin_oe & ext_drv);
endmodule : gpcb_board_model

// *** bench/tb_gpio_pin_config_bank.sv ***
`include "gpcb_params.svh"
module tb_gpio_pin_config_bank
  import gpcb_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int BASE = `GPCB_IDX_BANK1_PIN0_CFG;
  localparam logic [1:0] OK = `GPCB_RESP_OKAY;
  localparam logic [1:0] SLV = `GPCB_RESP_SLVERR;
  logic aclk, aresetn, standby_por_n;
  logic [7:0] awaddr, araddr, xout, xoe, xin, xsel, dd;
  logic awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, func;
  logic [8:0] pin_i, pin_o, pin_oe, gpio_out, gpio_in, ext_drv;
  logic fds_n, kbc_out, kbc_in, lock;
  logic ce;
  logic [8:0] gsave;
  gpcb_cfg_t shadow [9];
  int n_mismatch = 0;
  int n_checks = 0;
  int seed = 94;
  int k;
  logic [7:0] d;
  int bad [3] = '{-2, 9, 28};

  gpcb_top DUT (.aclk(aclk), .aresetn(aresetn), .ce(ce), .standby_por_n(standby_por_n),
    .s_axil_awaddr(awaddr), .s_axil_awprot(3'h0), .s_axil_awvalid(awvalid), .s_axil_awready(awready),
    .s_axil_wdata(wdata), .s_axil_wstrb(wstrb), .s_axil_wvalid(wvalid), .s_axil_wready(wready),
    .s_axil_bresp(bresp), .s_axil_bvalid(bvalid), .s_axil_bready(bready), .s_axil_araddr(araddr),
    .s_axil_arprot(3'h0), .s_axil_arvalid(arvalid), .s_axil_arready(arready), .s_axil_rdata(rdata),
    .s_axil_rresp(rresp), .s_axil_rvalid(rvalid), .s_axil_rready(rready), .pin_i(pin_i), .pin_o(pin_o),
    .pin_oe(pin_oe), .gpio_out_data(gpio_out), .gpio_in_data(gpio_in), .exp_bus_data_out(xout),
    .exp_bus_data_oe(xoe), .exp_bus_data_in(xin), .exp_bus_sel(xsel), .floppy_drive_select_1_n(fds_n),
    .kbc_port1_bit7_out(kbc_out), .kbc_port1_bit7_in(kbc_in), .bank2_pin0_func(func),
    .device_disable(dd), .reg_lock(lock));

  gpcb_board_model board (.pin_o(pin_o), .pin_oe(pin_oe), .ext_drv(ext_drv), .pin_i(pin_i));

  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end

  task automatic end_of_test();
    $display("Checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : end_of_test

  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, e, g);
    end
  endtask : chk

  function automatic logic [7:0] wmask(input int i);
    return i < 0 ? 8'heb : (i < 8 ? 8'h87 : 8'h8f);
  endfunction : wmask

  task automatic wr(input int i, input logic [7:0] v, input logic [3:0] s, input logic [1:0] er);
    logic [1:0] r;
    @(posedge aclk);
    awaddr <= 8'((BASE + i) * 4);
    awvalid <= 1'b1;
    wdata <= {24'h0, v};
    wstrb <= s;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid === 1'b1) begin
        r = bresp;
        bready <= 1'b0;
        break;
      end
    end
    chk("bresp", 32'(er), 32'(r));
  endtask : wr

  task automatic rd(input int i, input logic [7:0] e, input logic [1:0] er);
    logic [31:0] v;
    logic [1:0] r;
    @(posedge aclk);
    araddr <= 8'((BASE + i) * 4);
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid === 1'b1) begin
        v = rdata;
        r = rresp;
        rready <= 1'b0;
        break;
      end
    end
    chk("rdata", {24'h0, e}, v);
    chk("rresp", 32'(er), 32'(r));
  endtask : rd

  task automatic stim();
    @(posedge aclk);
    gpio_out <= 9'($random(seed));
    xout <= 8'($random(seed));
    xoe <= 8'($random(seed));
    ext_drv <= 9'($random(seed));
    fds_n <= 1'($random(seed));
    kbc_out <= 1'($random(seed));
    repeat (4) @(posedge aclk);
  endtask : stim

  task automatic check_pins();
    logic [8:0] oe_e, o_e, gin_e;
    logic [7:0] sel_e;
    logic v, en, p, kin_e;
    for (int j = 0; j < 9; j++) begin
      p = shadow[j][1];
      if (j < 8) begin
        sel_e[j] = shadow[j][2];
        v = shadow[j][2] ? xout[j] : gpio_out[j];
        en = shadow[j][2] ? xoe[j] : 1'b1;
      end else begin
        v = shadow[8][3] ? fds_n : (shadow[8][2] ? kbc_out : gpio_out[8]);
        en = shadow[8][3:2] != 2'b11;
      end
      v = v ^ p;
      en = en & ~shadow[j][0];
      oe_e[j] = shadow[j][7] ? en & ~v : en;
      o_e[j] = shadow[j][7] ? 1'b0 : v;
      gin_e[j] = (oe_e[j] ? o_e[j] : ext_drv[j]) ^ p;
    end
    kin_e = shadow[8][3:2] == 2'b01 ? gin_e[8] : 1'b1;
    @(negedge aclk);
    chk("pin_oe", 32'(oe_e), 32'(pin_oe));
    chk("pin_o", 32'(o_e & oe_e), 32'(pin_o & oe_e));
    chk("gpio_in", 32'(gin_e), 32'(gpio_in));
    chk("exp_in", 32'(gin_e[7:0] & sel_e), 32'(xin));
    chk("exp_sel", 32'(sel_e), 32'(xsel));
    chk("kbc_in", 32'(kin_e), 32'(kbc_in));
    chk("func", 32'(shadow[8][3:2]), 32'(func));
  endtask : check_pins

  task automatic defaults();
    for (int j = 0; j < 9; j++) shadow[j] = j < 8 ? 8'h04 : 8'h01;
    rd(-1, 8'h00, OK);
    for (int j = 0; j < 9; j++) rd(j, shadow[j], OK);
    stim();
    check_pins();
  endtask : defaults

  initial begin
    repeat (20000) @(posedge aclk);
    n_mismatch++;
    $display("Error watchdog expired");
    end_of_test();
  end

  initial begin
    {aresetn, standby_por_n, awvalid, wvalid, bready, arvalid, rready, fds_n, kbc_out} = '0;
    ce = 1'b1;
    {awaddr, araddr, wdata, wstrb, gpio_out, ext_drv, xout, xoe} = '0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    standby_por_n <= 1'b1;
    defaults();
    $display("Test defaults done");
    for (int f = 0; f < 4; f++) begin
      d = 8'($random(seed));
      d[3:2] = 2'(f);
      wr(8, d, 4'hf, OK);
      shadow[8] = d & wmask(8);
      rd(8, shadow[8], OK);
      stim();
      check_pins();
    end
    $display("Test functions done");
    repeat (60) begin
      k = $unsigned($random(seed)) % 9;
      d = 8'($random(seed));
      wr(k, d, 4'hf, OK);
      shadow[k] = d & wmask(k);
      rd(k, shadow[k], OK);
      stim();
      check_pins();
    end
    $display("Test random done");
    wr(4, 8'h01, 4'hf, OK);
    wr(8, 8'h05, 4'hf, OK);
    shadow[4] = 8'h01;
    shadow[8] = 8'h05;
    stim();
    check_pins();
    gsave = gpio_in;
    @(posedge aclk);
    ce <= 1'b0;
    ext_drv <= ~ext_drv;
    repeat (4) @(posedge aclk);
    @(negedge aclk);
    chk("gpio_in_frozen", 32'(gsave), 32'(gpio_in));
    chk("awready_frozen", 32'h0, 32'(awready));
    @(posedge aclk);
    ce <= 1'b1;
    repeat (3) @(posedge aclk);
    check_pins();
    $display("Test clock enable done");
    wr(3, ~shadow[3], 4'he, OK);
    rd(3, shadow[3], OK);
    foreach (bad[j]) begin
      wr(bad[j], 8'hff, 4'hf, SLV);
      rd(bad[j], 8'h00, SLV);
    end
    $display("Test refusals done");
    wr(-1, 8'hff, 4'hf, OK);
    @(negedge aclk);
    chk("reg_lock", 32'h1, 32'(lock));
    wr(0, ~shadow[0], 4'hf, OK);
    rd(0, shadow[0], OK);
    wr(-1, 8'h00, 4'hf, OK);
    rd(-1, 8'heb, OK);
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(negedge aclk);
    chk("reg_lock", 32'h0, 32'(lock));
    chk("device_disable", 32'he9, 32'(dd));
    rd(0, shadow[0], OK);
    wr(0, 8'h81, 4'hf, OK);
    shadow[0] = 8'h81;
    rd(0, shadow[0], OK);
    $display("Test lock done");
    @(posedge aclk);
    standby_por_n <= 1'b0;
    repeat (2) @(posedge aclk);
    standby_por_n <= 1'b1;
    defaults();
    $display("Test standby reset done");
    end_of_test();
  end
endmodule : tb_gpio_pin_config_bank
